/* src/umfc_consts.svh */
/*
  Constants of the UART mode, FIFO depth and clock selection block: register offsets,
  indexed offsets, field positions, reset values and depths.
  Assumes it is included once per compile unit by bare name; definitions only.
*/
// How it works
// RQ1: hardware reset clears FIFO enable, so both holding stores are one byte deep.
// RQ2: with FIFO enable clear the block is in byte mode, other mode bits ignored.
// RQ3: FIFO enable set, enhanced off, size bit clear gives 16-entry FIFOs.
// RQ4: FIFO enable set, enhanced off, size bit set gives 128-entry FIFOs.
// RQ5: FIFO size bit is writable only while the divisor latch access bit is set.
// RQ6: deep FIFO, auto RTS/CTS and sleep of legacy set work only outside enhanced mode.
// RQ7: enhanced mode with FIFO enable always gives 128 entries, size bit ignored.
// RQ8: enhanced mode unlocks in-band flow, special character, infrared, tx trigger, prescaler.
// RQ9: arbitrary trigger bit makes thresholds come from dedicated registers, not FIFO control.
// RQ10: software reads receive and transmit FIFO fill levels from two registers.
// RQ11: a status register shows flow state of local and remote transmitter.
// RQ12: prescaler divides system clock by M plus N/8, M in bits 7:3, N in 2:0.
// RQ13: prescaler ratio after reset is four.
// RQ14: external tx clock on ring input, rx clock on data-set-ready, tx clock out on DTR.
// RQ15: clock source select sits at index 0x02 of the indexed control space.
// RQ16: sample count per bit 4 to 15 selects exactly that many sample clocks.
// RQ17: sample count resets to 0x00; values 0 to 3 mean 16 samples per bit.
// RQ18: in enhanced mode transmitter and receiver can be disabled separately.
// RQ19: optional buffer-enable output drives an external RS-485 driver while transmitting.
// RQ20: automatic flow control also works on the DSR input and DTR output.
// RQ21: a software reset returns the core to its reset state.
// RQ22: bit rate is clock over prescaler ratio, divisor and samples per bit.
`ifndef UMFC_CONSTS_SVH
`define UMFC_CONSTS_SVH
// direct register offsets
`define UMFC_A_FIFO_CTRL 5'h00
`define UMFC_A_LINE_CTRL 5'h01
`define UMFC_A_ENH_FEAT 5'h02
`define UMFC_A_ADD_CTRL 5'h03
`define UMFC_A_ICR_INDEX 5'h04
`define UMFC_A_ICR_DATA 5'h05
`define UMFC_A_DIV_LO 5'h06
`define UMFC_A_DIV_HI 5'h07
`define UMFC_A_MODE_STAT 5'h08
`define UMFC_A_RX_FILL 5'h09
`define UMFC_A_TX_FILL 5'h0A
`define UMFC_A_ADD_STAT 5'h0B
`define UMFC_A_DATA 5'h0C
`define UMFC_A_LEG_CTRL 5'h0D
// indexed control space
`define UMFC_I_PRESC 8'h01
`define UMFC_I_CLK_SEL 8'h02
`define UMFC_I_SAMPLES 8'h03
`define UMFC_I_RX_THR 8'h04
`define UMFC_I_TX_THR 8'h05
`define UMFC_I_FLOW_LO 8'h06
`define UMFC_I_FLOW_HI 8'h07
`define UMFC_I_SOFT_RST 8'h08
// field positions
`define UMFC_FCR_EN 0
`define UMFC_FCR_FLUSH_RX 1
`define UMFC_FCR_FLUSH_TX 2
`define UMFC_FCR_SIZE 5
`define UMFC_LCR_DLAB 7
`define UMFC_EFR_ENH 4
`define UMFC_EFR_SPECIAL 5
`define UMFC_EFR_AUTO_RTS 6
`define UMFC_EFR_AUTO_CTS 7
`define UMFC_ACR_RX_DIS 1
`define UMFC_ACR_TX_DIS 2
`define UMFC_ACR_RS485 3
`define UMFC_ACR_DTR_FLOW 4
`define UMFC_ACR_ARB_TRIG 5
`define UMFC_LEG_SLEEP 4
`define UMFC_LEG_AUTO_FLOW 5
`define UMFC_LEG_IRDA 6
`define UMFC_LEG_PRESC 7
`define UMFC_CKS_RX_EXT 0
`define UMFC_CKS_TX_EXT 1
`define UMFC_CKS_DTR_CLK 2
`define UMFC_CKS_ONE_X 3
// reset values and depths
`define UMFC_PRESC_RST 8'h20
`define UMFC_SAMPLES_RST 8'h00
`define UMFC_RX_THR_RST 8'h01
`define UMFC_FLOW_HI_RST 8'h70
`define UMFC_FLOW_LO_RST 8'h10
`define UMFC_DEPTH_BYTE 8'h01
`define UMFC_DEPTH_SHORT 8'h10
`define UMFC_DEPTH_DEEP 8'h80
`define UMFC_SAMPLES_STD 5'h10
`define UMFC_SAMPLES_MIN 8'h04
`define UMFC_SAMPLES_MAX 8'h0F
`define UMFC_EIGHTHS 9'h008
`endif

/* src/umfc_pkg.sv */
/*
  Types of the UART mode, FIFO depth and clock selection block.
  Assumes umfc_consts.svh carries every number.
*/
package umfc_pkg;
  // compatibility level, Gray coded along byte -> short -> deep -> enhanced
  typedef enum logic [1:0] {
    UMFC_MODE_BYTE = 2'h0,
    UMFC_MODE_SHORT = 2'h1,
    UMFC_MODE_DEEP = 2'h3,
    UMFC_MODE_ENH = 2'h2
  } umfc_mode_t;
  // modem-side inputs, all active low as on the pins
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic ri_n;
  } umfc_modem_t;
  // feature enables handed to the rest of the core
  typedef struct packed {
    logic inband_flow;
    logic special_char;
    logic irda;
    logic sleep;
    logic rx_enable;
    logic tx_enable;
  } umfc_feat_t;
endpackage

/* src/umfc_core.sv */
/*
  Mode selection, FIFO depth, fill levels, flow state and bit clock generation of
  a compatible UART core, with its register file on a plain strobe port.
  Assumes a single 100 MHz clock, synchronous pins and a core that reports
  characters received and sent by one-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "umfc_consts.svh"
module umfc_core
  import umfc_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // register port
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // character events from the serial core
  input wire logic rx_char_in,
  input wire logic tx_char_done_in,
  input wire logic tx_busy_in,
  // modem pins
  input wire umfc_modem_t modem_in,
  output logic rts_n_out,
  output logic dtr_n_out,
  output logic rs485_en_out,
  // mode and clocks to the serial core
  output umfc_mode_t mode_out,
  output umfc_feat_t feat_out,
  output logic tx_hold_out,
  output logic rx_trigger_out,
  output logic tx_trigger_out,
  output logic tx_sample_tick_out,
  output logic tx_bit_tick_out,
  output logic rx_sample_tick_out
);
  logic [7:0] fcr_r, lcr_r, efr_r, acr_r, leg_r, icr_idx_r;
  logic [7:0] cpr_r, cks_r, tcr_r, rx_thr_r, tx_thr_r, flow_lo_r, flow_hi_r;
  logic [15:0] div_r;
  logic [7:0] rx_lvl_r, tx_lvl_r;
  logic soft_rst_r, flow_stop_r, rst;
  logic enh, fifo_en, data_rd, data_wr, icr_wr;
  umfc_mode_t mode;
  logic [7:0] depth, rx_thr, tx_thr, lo_thr, hi_thr, rd_mux, icr_mux;

  // soft reset is held for one cycle and clears everything hardware reset clears
  assign rst = !rst_n_in || soft_rst_r; // RQ21
  assign enh = efr_r[`UMFC_EFR_ENH];
  assign fifo_en = fcr_r[`UMFC_FCR_EN];
  assign data_rd = rd_in && addr_in == `UMFC_A_DATA;
  assign data_wr = wr_in && addr_in == `UMFC_A_DATA;
  assign icr_wr = wr_in && addr_in == `UMFC_A_ICR_DATA;

  always_comb begin
    if (!fifo_en) begin
      mode = UMFC_MODE_BYTE; // RQ2
    end else if (enh) begin
      mode = UMFC_MODE_ENH; // RQ7
    end else if (fcr_r[`UMFC_FCR_SIZE]) begin
      mode = UMFC_MODE_DEEP; // RQ4 RQ6
    end else begin
      mode = UMFC_MODE_SHORT; // RQ3
    end
  end

  always_comb begin
    case (mode)
      UMFC_MODE_BYTE: depth = `UMFC_DEPTH_BYTE; // RQ1
      UMFC_MODE_SHORT: depth = `UMFC_DEPTH_SHORT;
      UMFC_MODE_DEEP: depth = `UMFC_DEPTH_DEEP;
      UMFC_MODE_ENH: depth = `UMFC_DEPTH_DEEP;
      default: depth = `UMFC_DEPTH_BYTE;
    endcase
  end

  // legacy trigger table follows the usual 1/4/8/14 steps of a 16-deep FIFO
  always_comb begin
    if (acr_r[`UMFC_ACR_ARB_TRIG]) begin
      rx_thr = rx_thr_r; // RQ9
      tx_thr = tx_thr_r;
      lo_thr = flow_lo_r;
      hi_thr = flow_hi_r;
    end else begin
      case (fcr_r[7:6])
        2'h0: rx_thr = 8'h01;
        2'h1: rx_thr = 8'h04;
        2'h2: rx_thr = 8'h08;
        default: rx_thr = 8'h0E;
      endcase
      tx_thr = 8'h00;
      lo_thr = 8'h00;
      hi_thr = rx_thr;
    end
  end

  // control registers
  always_ff @(posedge clock_in) begin
    if (rst) begin
      fcr_r <= 8'h00; // RQ1
      lcr_r <= 8'h00;
      efr_r <= 8'h00;
      acr_r <= 8'h00;
      leg_r <= 8'h00;
      icr_idx_r <= 8'h00;
      div_r <= 16'h0001;
    end else if (clk_en_in && wr_in) begin
      case (addr_in)
        `UMFC_A_FIFO_CTRL: begin
          fcr_r[7:6] <= wdata_in[7:6];
          fcr_r[4:3] <= wdata_in[4:3];
          fcr_r[`UMFC_FCR_EN] <= wdata_in[`UMFC_FCR_EN];
          if (lcr_r[`UMFC_LCR_DLAB]) begin
            fcr_r[`UMFC_FCR_SIZE] <= wdata_in[`UMFC_FCR_SIZE]; // RQ5
          end
        end
        `UMFC_A_LINE_CTRL: lcr_r <= wdata_in;
        `UMFC_A_ENH_FEAT: efr_r <= wdata_in;
        `UMFC_A_ADD_CTRL: acr_r <= wdata_in;
        `UMFC_A_LEG_CTRL: leg_r <= wdata_in;
        `UMFC_A_ICR_INDEX: icr_idx_r <= wdata_in;
        `UMFC_A_DIV_LO: div_r[7:0] <= wdata_in;
        `UMFC_A_DIV_HI: div_r[15:8] <= wdata_in;
        default: ;
      endcase
    end
  end

  // indexed control space
  always_ff @(posedge clock_in) begin
    if (rst) begin
      cpr_r <= `UMFC_PRESC_RST; // RQ13
      cks_r <= 8'h00;
      tcr_r <= `UMFC_SAMPLES_RST; // RQ17
      rx_thr_r <= `UMFC_RX_THR_RST;
      tx_thr_r <= 8'h00;
      flow_lo_r <= `UMFC_FLOW_LO_RST;
      flow_hi_r <= `UMFC_FLOW_HI_RST;
    end else if (clk_en_in && icr_wr) begin
      case (icr_idx_r)
        `UMFC_I_PRESC: cpr_r <= wdata_in;
        `UMFC_I_CLK_SEL: cks_r <= wdata_in; // RQ15
        `UMFC_I_SAMPLES: tcr_r <= wdata_in;
        `UMFC_I_RX_THR: rx_thr_r <= wdata_in;
        `UMFC_I_TX_THR: tx_thr_r <= wdata_in;
        `UMFC_I_FLOW_LO: flow_lo_r <= wdata_in;
        `UMFC_I_FLOW_HI: flow_hi_r <= wdata_in;
        default: ;
      endcase
    end
  end

  // soft reset flop answers only to the pin, or it would hold itself forever
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      soft_rst_r <= 1'b0;
    end else if (clk_en_in) begin
      soft_rst_r <= icr_wr && icr_idx_r == `UMFC_I_SOFT_RST; // RQ21
    end
  end

  // fill levels; each flush bit empties its own FIFO, turning the FIFOs on or off empties both
  logic fifo_flip, rx_push, rx_pop, tx_push, tx_pop;
  assign fifo_flip = wr_in && addr_in == `UMFC_A_FIFO_CTRL && wdata_in[`UMFC_FCR_EN] != fifo_en;
  assign rx_push = rx_char_in && feat_out.rx_enable && rx_lvl_r < depth;
  assign rx_pop = data_rd && rx_lvl_r != 8'h00;
  assign tx_push = data_wr && tx_lvl_r < depth;
  assign tx_pop = tx_char_done_in && tx_lvl_r != 8'h00;

  always_ff @(posedge clock_in) begin
    if (rst) begin
      rx_lvl_r <= 8'h00;
    end else if (clk_en_in) begin
      if (fifo_flip || (wr_in && addr_in == `UMFC_A_FIFO_CTRL && wdata_in[`UMFC_FCR_FLUSH_RX])) begin
        rx_lvl_r <= 8'h00;
      end else if (rx_push && !rx_pop) begin
        rx_lvl_r <= rx_lvl_r + 8'h01; // RQ10
      end else if (rx_pop && !rx_push) begin
        rx_lvl_r <= rx_lvl_r - 8'h01;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst) begin
      tx_lvl_r <= 8'h00;
    end else if (clk_en_in) begin
      if (fifo_flip || (wr_in && addr_in == `UMFC_A_FIFO_CTRL && wdata_in[`UMFC_FCR_FLUSH_TX])) begin
        tx_lvl_r <= 8'h00;
      end else if (tx_push && !tx_pop) begin
        tx_lvl_r <= tx_lvl_r + 8'h01; // RQ10
      end else if (tx_pop && !tx_push) begin
        tx_lvl_r <= tx_lvl_r - 8'h01;
      end
    end
  end

  // receive flow: stop the peer at the high mark, release at the low mark
  logic rx_auto_flow, tx_auto_flow, peer_stop;
  assign rx_auto_flow = enh ? efr_r[`UMFC_EFR_AUTO_RTS] : leg_r[`UMFC_LEG_AUTO_FLOW]; // RQ6
  assign tx_auto_flow = enh ? efr_r[`UMFC_EFR_AUTO_CTS] : leg_r[`UMFC_LEG_AUTO_FLOW];
  assign peer_stop = modem_in.cts_n || (acr_r[`UMFC_ACR_DTR_FLOW] && modem_in.dsr_n); // RQ20

  always_ff @(posedge clock_in) begin
    if (rst) begin
      flow_stop_r <= 1'b0;
    end else if (clk_en_in) begin
      if (!rx_auto_flow) begin
        flow_stop_r <= 1'b0;
      end else if (rx_lvl_r >= hi_thr) begin
        flow_stop_r <= 1'b1;
      end else if (rx_lvl_r <= lo_thr) begin
        flow_stop_r <= 1'b0;
      end
    end
  end

  // bit clock chain: fractional prescaler, divisor, samples per bit
  logic [8:0] presc_acc_r, ratio8;
  logic [15:0] div_cnt_r;
  logic [4:0] spb, tx_smp_r, rx_smp_r;
  logic presc_tick, int_sample, presc_on;
  assign presc_on = enh && leg_r[`UMFC_LEG_PRESC]; // RQ8
  // M of zero gives a ratio of exactly one, N ignored, so the ratio never falls below 1
  assign ratio8 = (cpr_r[7:3] == 5'h00) ? `UMFC_EIGHTHS : {1'b0, cpr_r}; // RQ12
  assign presc_tick = !presc_on || (presc_acc_r + `UMFC_EIGHTHS >= ratio8);
  assign int_sample = presc_tick && div_cnt_r <= 16'h0001;
  assign spb = (tcr_r < `UMFC_SAMPLES_MIN || tcr_r > `UMFC_SAMPLES_MAX) ?
    `UMFC_SAMPLES_STD : tcr_r[4:0]; // RQ16 RQ17

  always_ff @(posedge clock_in) begin
    if (rst) begin
      presc_acc_r <= 9'h000;
    end else if (clk_en_in && presc_on) begin
      if (presc_tick) begin
        presc_acc_r <= presc_acc_r + `UMFC_EIGHTHS - ratio8; // RQ12
      end else begin
        presc_acc_r <= presc_acc_r + `UMFC_EIGHTHS;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst) begin
      div_cnt_r <= 16'h0001;
    end else if (clk_en_in && presc_tick) begin
      div_cnt_r <= (div_cnt_r <= 16'h0001) ? div_r : div_cnt_r - 16'h0001; // RQ22
    end
  end

  // external clocks: edges on ring and data-set-ready replace the internal ticks
  logic ri_q_r, dsr_q_r, ri_edge, dsr_edge, tx_ext, rx_ext, one_x;
  logic tx_sample, rx_sample, tx_bit, dtr_clk_r;
  assign tx_ext = enh && cks_r[`UMFC_CKS_TX_EXT]; // RQ14
  assign rx_ext = enh && cks_r[`UMFC_CKS_RX_EXT];
  assign one_x = cks_r[`UMFC_CKS_ONE_X];
  assign ri_edge = ri_q_r && !modem_in.ri_n;
  assign dsr_edge = dsr_q_r && !modem_in.dsr_n;
  assign tx_sample = tx_ext ? ri_edge : int_sample;
  assign rx_sample = rx_ext ? dsr_edge : int_sample;
  assign tx_bit = (tx_ext && one_x) ? ri_edge : (tx_sample && tx_smp_r <= 5'h01);

  always_ff @(posedge clock_in) begin
    if (rst) begin
      ri_q_r <= 1'b1;
      dsr_q_r <= 1'b1;
    end else if (clk_en_in) begin
      ri_q_r <= modem_in.ri_n;
      dsr_q_r <= modem_in.dsr_n;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst) begin
      tx_smp_r <= `UMFC_SAMPLES_STD;
    end else if (clk_en_in && tx_sample) begin
      tx_smp_r <= (tx_smp_r <= 5'h01) ? spb : tx_smp_r - 5'h01; // RQ16 RQ22
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst) begin
      rx_smp_r <= `UMFC_SAMPLES_STD;
    end else if (clk_en_in && rx_sample) begin
      rx_smp_r <= (rx_smp_r <= 5'h01) ? spb : rx_smp_r - 5'h01;
    end
  end

  // transmit clock on DTR toggles once per bit, so it runs at half the bit rate
  always_ff @(posedge clock_in) begin
    if (rst) begin
      dtr_clk_r <= 1'b0;
    end else if (clk_en_in && tx_bit) begin
      dtr_clk_r <= !dtr_clk_r; // RQ14
    end
  end

  // register read mux
  always_comb begin
    case (icr_idx_r)
      `UMFC_I_PRESC: icr_mux = cpr_r;
      `UMFC_I_CLK_SEL: icr_mux = cks_r;
      `UMFC_I_SAMPLES: icr_mux = tcr_r;
      `UMFC_I_RX_THR: icr_mux = rx_thr_r;
      `UMFC_I_TX_THR: icr_mux = tx_thr_r;
      `UMFC_I_FLOW_LO: icr_mux = flow_lo_r;
      `UMFC_I_FLOW_HI: icr_mux = flow_hi_r;
      default: icr_mux = 8'h00;
    endcase
  end

  always_comb begin
    case (addr_in)
      `UMFC_A_FIFO_CTRL: rd_mux = {fcr_r[7:3], 2'h0, fcr_r[0]};
      `UMFC_A_LINE_CTRL: rd_mux = lcr_r;
      `UMFC_A_ENH_FEAT: rd_mux = efr_r;
      `UMFC_A_ADD_CTRL: rd_mux = acr_r;
      `UMFC_A_ICR_INDEX: rd_mux = icr_idx_r;
      `UMFC_A_ICR_DATA: rd_mux = icr_mux;
      `UMFC_A_DIV_LO: rd_mux = div_r[7:0];
      `UMFC_A_DIV_HI: rd_mux = div_r[15:8];
      `UMFC_A_MODE_STAT: rd_mux = {6'h00, mode};
      `UMFC_A_RX_FILL: rd_mux = rx_lvl_r; // RQ10
      `UMFC_A_TX_FILL: rd_mux = tx_lvl_r;
      `UMFC_A_ADD_STAT: rd_mux = {6'h00, flow_stop_r, tx_auto_flow && peer_stop}; // RQ11
      `UMFC_A_LEG_CTRL: rd_mux = leg_r;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst) begin
      rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      rdata_out <= rd_in ? rd_mux : 8'h00;
    end
  end

  // registered outputs
  always_ff @(posedge clock_in) begin
    if (rst) begin
      mode_out <= UMFC_MODE_BYTE;
      feat_out <= '0;
      rts_n_out <= 1'b1;
      dtr_n_out <= 1'b1;
      rs485_en_out <= 1'b0;
      tx_hold_out <= 1'b0;
      rx_trigger_out <= 1'b0;
      tx_trigger_out <= 1'b0;
      tx_sample_tick_out <= 1'b0;
      tx_bit_tick_out <= 1'b0;
      rx_sample_tick_out <= 1'b0;
    end else if (clk_en_in) begin
      mode_out <= mode;
      feat_out.inband_flow <= enh && efr_r[3:0] != 4'h0; // RQ8
      feat_out.special_char <= enh && efr_r[`UMFC_EFR_SPECIAL];
      feat_out.irda <= enh && leg_r[`UMFC_LEG_IRDA];
      feat_out.sleep <= !enh && leg_r[`UMFC_LEG_SLEEP]; // RQ6
      feat_out.rx_enable <= !(enh && acr_r[`UMFC_ACR_RX_DIS]); // RQ18
      feat_out.tx_enable <= !(enh && acr_r[`UMFC_ACR_TX_DIS]);
      rts_n_out <= flow_stop_r;
      if (enh && cks_r[`UMFC_CKS_DTR_CLK]) begin
        dtr_n_out <= dtr_clk_r; // RQ14
      end else begin
        dtr_n_out <= acr_r[`UMFC_ACR_DTR_FLOW] && flow_stop_r; // RQ20
      end
      rs485_en_out <= acr_r[`UMFC_ACR_RS485] && tx_busy_in; // RQ19
      tx_hold_out <= tx_auto_flow && peer_stop; // RQ11
      rx_trigger_out <= rx_lvl_r != 8'h00 && rx_lvl_r >= rx_thr; // RQ9
      // byte mode ignores the enhanced bit, so the trigger follows the decoded mode
      tx_trigger_out <= mode == UMFC_MODE_ENH && tx_lvl_r <= tx_thr; // RQ8 RQ2
      tx_sample_tick_out <= tx_sample;
      tx_bit_tick_out <= tx_bit; // RQ22
      rx_sample_tick_out <= rx_sample;
    end
  end
endmodule
`default_nettype wire

/* testbench/umfc_core_checker.sv */
/*
  Port assertions for umfc_core: register read timing, reset state,
  mode override, RS-485 enable and bit tick spacing.
  Assumes one clock domain and the bind statement at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "umfc_consts.svh"
module umfc_core_checker
  import umfc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // register port
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // pins and mode
  input wire logic tx_busy_in,
  input wire logic rts_n_out,
  input wire logic dtr_n_out,
  input wire logic rs485_en_out,
  input wire umfc_mode_t mode_out,
  input wire logic tx_trigger_out,
  input wire logic tx_bit_tick_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // cycles since the last bit tick; starts saturated so the first tick is free
  logic [7:0] gap_r;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      gap_r <= 8'hFF;
    end else if (tx_bit_tick_out) begin
      gap_r <= 8'h00;
    end else if (gap_r != 8'hFF) begin
      gap_r <= gap_r + 8'h01;
    end
  end

  a_reset_state: assert property (disable iff (1'b0)
    (!rst_n_in && clk_en_in) |=> (mode_out == UMFC_MODE_BYTE && rts_n_out && dtr_n_out && rdata_out == 8'h00))
    else $error("reset state wrong");
  a_idle_rdata: assert property ((!rd_in && clk_en_in) |=> rdata_out == 8'h00)
    else $error("read data not zero without read");
  a_unmapped_zero: assert property ((rd_in && clk_en_in && addr_in == 5'h1F) |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_data_read_zero: assert property ((rd_in && clk_en_in && addr_in == `UMFC_A_DATA) |=> rdata_out == 8'h00)
    else $error("data read not zero");
  a_byte_override: assert property (
    (wr_in && clk_en_in && addr_in == `UMFC_A_FIFO_CTRL && !wdata_in[0])
    ##1 (clk_en_in && !(wr_in && addr_in == `UMFC_A_FIFO_CTRL)) |=> mode_out == UMFC_MODE_BYTE)
    else $error("fifo disable did not give byte mode");
  a_rs485_drop: assert property ((!tx_busy_in && clk_en_in) |=> !rs485_en_out)
    else $error("rs485 enable without busy");
  a_bit_spacing: assert property (tx_bit_tick_out |-> gap_r >= 8'h03)
    else $error("bit ticks closer than four cycles");
  a_trig_enh_only: assert property ((mode_out != UMFC_MODE_ENH)[*2] |-> !tx_trigger_out)
    else $error("tx trigger outside enhanced mode");
endmodule

bind umfc_core umfc_core_checker u_chk (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .tx_busy_in(tx_busy_in), .rts_n_out(rts_n_out), .dtr_n_out(dtr_n_out),
  .rs485_en_out(rs485_en_out), .mode_out(mode_out), .tx_trigger_out(tx_trigger_out),
  .tx_bit_tick_out(tx_bit_tick_out)
);
`default_nettype wire

/* testbench/umfc_peer.sv */
/*
  Remote serial peer: drives the modem status pins of the block.
  Assumes the bench tells it when to hold off and when to clock on ring input.
*/
`timescale 1ns/1ps
`default_nettype none
module umfc_peer
  import umfc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // commands from the bench
  input wire logic hold_in,
  input wire logic ri_run_in,
  // modem pins toward the block
  output umfc_modem_t modem_out
);
  logic [1:0] ph_r;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !ri_run_in) begin
      ph_r <= 2'h0;
    end else begin
      ph_r <= ph_r + 2'h1;
    end
  end
  // ring line idles high between bursts, one falling edge per four cycles
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      modem_out <= 3'h7;
    end else begin
      modem_out.cts_n <= hold_in;
      modem_out.dsr_n <= 1'b1;
      modem_out.ri_n <= !(ri_run_in && ph_r[1]);
    end
  end
endmodule
`default_nettype wire

/* testbench/umfc_core_tb_top.sv */
/*
  Directed testbench for umfc_core: register tasks on the strobe port and
  scenarios for modes, depths, thresholds, flow and bit clocks.
  Assumes umfc_peer on the modem pins and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "umfc_consts.svh"
module umfc_core_tb_top;
  import umfc_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [4:0] addr_r = 5'h00;
  logic [7:0] wdata_r = 8'h00;
  logic wr_r = 1'b0;
  logic rd_r = 1'b0;
  logic rx_r = 1'b0;
  logic txd_r = 1'b0;
  logic busy_r = 1'b0;
  logic hold_r = 1'b0;
  logic run_r = 1'b0;
  umfc_modem_t modem;
  umfc_mode_t mode;
  umfc_feat_t feat;
  logic [7:0] rdata;
  logic rts_n, dtr_n, rs485, hold, rxt, txt, txs, txb, rxs;
  int error_cnt = 0;
  int tests_run = 0;
  int n;
  logic [7:0] tcr_v [5] = '{8'h00, 8'h02, 8'h04, 8'h0D, 8'h0F};
  logic [7:0] spb_v [5] = '{8'h10, 8'h10, 8'h04, 8'h0D, 8'h0F};

  umfc_core dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1), .addr_in(addr_r),
    .wdata_in(wdata_r), .wr_in(wr_r), .rd_in(rd_r), .rdata_out(rdata), .rx_char_in(rx_r),
    .tx_char_done_in(txd_r), .tx_busy_in(busy_r), .modem_in(modem), .rts_n_out(rts_n),
    .dtr_n_out(dtr_n), .rs485_en_out(rs485), .mode_out(mode), .feat_out(feat),
    .tx_hold_out(hold), .rx_trigger_out(rxt), .tx_trigger_out(txt),
    .tx_sample_tick_out(txs), .tx_bit_tick_out(txb), .rx_sample_tick_out(rxs)
  );
  umfc_peer peer (.clock_in(clock_in), .rst_n_in(rst_n_in), .hold_in(hold_r), .ri_run_in(run_r),
    .modem_out(modem));

  initial begin
    forever #5 clock_in = ~clock_in;
  end

  task automatic complete_run;
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    @(posedge clock_in);
    addr_r <= a;
    wdata_r <= d;
    wr_r <= 1'b1;
    @(posedge clock_in);
    wr_r <= 1'b0;
  endtask
  task automatic rd(logic [4:0] a, logic [7:0] exp, string what);
    @(posedge clock_in);
    addr_r <= a;
    rd_r <= 1'b1;
    @(posedge clock_in);
    rd_r <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask
  task automatic iw(logic [7:0] i, logic [7:0] d);
    wr(`UMFC_A_ICR_INDEX, i);
    wr(`UMFC_A_ICR_DATA, d);
  endtask
  task automatic ir(logic [7:0] i, logic [7:0] exp, string what);
    wr(`UMFC_A_ICR_INDEX, i);
    rd(`UMFC_A_ICR_DATA, exp, what);
  endtask
  task automatic mchk(umfc_mode_t m);
    tick(1);
    chk("mode", {6'h00, m}, {6'h00, mode});
  endtask
  task automatic rxp(int k);
    @(posedge clock_in);
    rx_r <= 1'b1;
    repeat (k) @(posedge clock_in);
    rx_r <= 1'b0;
  endtask
  task automatic txp(int k);
    repeat (k) wr(`UMFC_A_DATA, 8'h5A);
  endtask
  // cycles from the first tick seen through the tick k bit periods later, both tick cycles counted (k periods plus one)
  task automatic span(int k, output int c);
    int t;
    t = 0;
    c = 0;
    while (t < k + 1 && c < 5000) begin
      @(posedge clock_in);
      #1;
      if (txb) t++;
      if (t > 0) c++;
    end
  endtask

  initial begin
    repeat (20000) @(posedge clock_in);
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    mchk(UMFC_MODE_BYTE);
    ir(`UMFC_I_PRESC, 8'h20, "prescaler reset");
    ir(`UMFC_I_SAMPLES, 8'h00, "samples reset");
    rd(5'h1F, 8'h00, "unmapped");
    txp(2);
    rd(`UMFC_A_TX_FILL, 8'h01, "byte tx level");
    rxp(3);
    rd(`UMFC_A_RX_FILL, 8'h01, "byte rx level");
    wr(`UMFC_A_FIFO_CTRL, 8'h01);
    mchk(UMFC_MODE_SHORT);
    txp(17);
    rd(`UMFC_A_TX_FILL, 8'h10, "short tx level");
    wr(`UMFC_A_FIFO_CTRL, 8'h21);
    mchk(UMFC_MODE_SHORT);
    wr(`UMFC_A_LINE_CTRL, 8'h80);
    wr(`UMFC_A_FIFO_CTRL, 8'h21);
    wr(`UMFC_A_LINE_CTRL, 8'h00);
    mchk(UMFC_MODE_DEEP);
    wr(`UMFC_A_FIFO_CTRL, 8'h05);
    txp(130);
    rd(`UMFC_A_TX_FILL, 8'h80, "deep tx level");
    @(posedge clock_in);
    txd_r <= 1'b1;
    repeat (2) @(posedge clock_in);
    txd_r <= 1'b0;
    rd(`UMFC_A_TX_FILL, 8'h7E, "tx level after send");
    wr(`UMFC_A_LEG_CTRL, 8'h10);
    tick(1);
    chk("legacy sleep", 8'h01, {7'h00, feat.sleep});
    wr(`UMFC_A_ENH_FEAT, 8'h10);
    mchk(UMFC_MODE_ENH);
    chk("enhanced sleep", 8'h00, {7'h00, feat.sleep});
    wr(`UMFC_A_LINE_CTRL, 8'h80);
    wr(`UMFC_A_FIFO_CTRL, 8'h07);
    wr(`UMFC_A_LINE_CTRL, 8'h00);
    txp(130);
    rd(`UMFC_A_TX_FILL, 8'h80, "enhanced tx level");
    wr(`UMFC_A_FIFO_CTRL, 8'h20);
    mchk(UMFC_MODE_BYTE);
    chk("byte tx trigger", 8'h00, {7'h00, txt});
    wr(`UMFC_A_FIFO_CTRL, 8'hC1);
    wr(`UMFC_A_ADD_CTRL, 8'h20);
    iw(`UMFC_I_RX_THR, 8'h03);
    rxp(2);
    tick(2);
    chk("rx trigger low", 8'h00, {7'h00, rxt});
    rxp(1);
    tick(2);
    chk("rx trigger high", 8'h01, {7'h00, rxt});
    chk("tx trigger", 8'h01, {7'h00, txt});
    wr(`UMFC_A_ADD_CTRL, 8'h02);
    rxp(1);
    tick(1);
    chk("rx enable", 8'h00, {7'h00, feat.rx_enable});
    rd(`UMFC_A_RX_FILL, 8'h03, "rx level disabled");
    wr(`UMFC_A_ENH_FEAT, 8'h90);
    @(posedge clock_in);
    hold_r <= 1'b1;
    tick(4);
    chk("tx hold", 8'h01, {7'h00, hold});
    rd(`UMFC_A_ADD_STAT, 8'h01, "flow status");
    @(posedge clock_in);
    hold_r <= 1'b0;
    tick(4);
    chk("tx hold off", 8'h00, {7'h00, hold});
    wr(`UMFC_A_ADD_CTRL, 8'h08);
    @(posedge clock_in);
    busy_r <= 1'b1;
    tick(3);
    chk("rs485 on", 8'h01, {7'h00, rs485});
    wr(`UMFC_A_LEG_CTRL, 8'h80);
    iw(`UMFC_I_PRESC, 8'h0C);
    wr(`UMFC_A_DIV_LO, 8'h02);
    iw(`UMFC_I_SAMPLES, 8'h04);
    span(4, n);
    chk("prescaled span", 8'h30, 8'(n - 1));
    iw(`UMFC_I_SOFT_RST, 8'h00);
    mchk(UMFC_MODE_BYTE);
    ir(`UMFC_I_PRESC, 8'h20, "prescaler soft reset");
    for (int i = 0; i < 5; i++) begin
      iw(`UMFC_I_SAMPLES, tcr_v[i]);
      span(4, n);
      chk("bit span", spb_v[i] << 2, 8'(n - 1));
    end
    iw(`UMFC_I_SOFT_RST, 8'h00);
    wr(`UMFC_A_DIV_HI, 8'hFF);
    wr(`UMFC_A_ENH_FEAT, 8'h10);
    iw(`UMFC_I_CLK_SEL, 8'h0E);
    ir(`UMFC_I_CLK_SEL, 8'h0E, "clock select");
    @(posedge clock_in);
    run_r <= 1'b1;
    n = 0;
    for (int i = 0; i < 24; i++) begin
      @(posedge clock_in);
      if (i == 11) run_r <= 1'b0;
      #1;
      if (txb) n++;
    end
    chk("external ticks", 8'h03, 8'(n));
    chk("dtr clock", 8'h01, {7'h00, dtr_n});
    complete_run();
  end
endmodule
`default_nettype wire
